// ---- flash_prog_uart_setup_erase_cmds_test.sv ----
// self-checking bench joining the programmer end to the device end
module flash_prog_uart_setup_erase_cmds_test
  import fpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FMAX  = 32'h00FF_FFFF;
  localparam int          LIMIT = 1_500_000;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          cmd_start = 1'b0;
  fpsc_kind_type cmd_kind = FPSC_FREQ;
  logic [31:0]   cmd_arg = '0;
  logic          prohibit = 1'b0;
  logic          erase_done = 1'b0;
  logic [1:0]    erase_result = 2'h0;
  logic          busy, done, ok, timed_out, erase_req, dev_busy;
  logic [7:0]    result, baud_code, dev_baud_code, code;
  logic [31:0]   osc_freq;
  logic [31:0]   fv [4];
  int            n_mismatch = 0;
  int            cmp_count = 0;
  int            cyc = 0;

  fpsc_link_if link ();
  fpsc_prog #(.GAP_US(1), .SWITCH_US(1), .RESET_TMO_MS(1), .FREQ_TMO_MS(1), .ERASE_TMO_MS(1))
    u_fpsc_prog (.clk(clk), .rst(rst), .link(link), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
    .cmd_arg(cmd_arg), .busy(busy), .done(done), .ok(ok), .timed_out(timed_out),
    .result(result), .baud_code(baud_code));
  fpsc_dev u_fpsc_dev (.clk(clk), .rst(rst), .link(link), .erase_prohibit(prohibit),
    .erase_done(erase_done), .erase_result(erase_result), .erase_req(erase_req),
    .busy(dev_busy), .osc_freq(osc_freq), .baud_code(dev_baud_code));
  fpsc_properties u_fpsc_properties (.clk(clk), .rst(rst),
    .p2d_txd(link.p2d_txd), .d2p_txd(link.d2p_txd), .cmd_start(cmd_start), .busy(busy),
    .done(done), .ok(ok), .timed_out(timed_out), .result(result), .baud_code(baud_code),
    .dev_baud_code(dev_baud_code), .erase_req(erase_req), .dev_busy(dev_busy));

  // clock and hang watchdog
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // expected status codes
  function automatic logic [7:0] freq_code(input logic [31:0] f);
    return (f >= 32'h1 && f <= FMAX) ? ST_ACK : ST_PARAM;
  endfunction
  function automatic logic [7:0] erase_code(input logic [1:0] r);
    logic [7:0] t [4] = '{8'h06, 8'h1C, 8'h1A, 8'h1B};
    return t[r];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic run_cmd(input fpsc_kind_type k, input logic [31:0] a);
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_kind <= k;
    cmd_arg <= a;
    @(posedge clk);
    cmd_start <= 1'b0;
    do @(posedge clk); while (done !== 1'b1); // done as sampled at the edge
  endtask

  task automatic pulse_done(input logic [1:0] r);
    @(posedge clk);
    erase_result <= r;
    erase_done <= 1'b1;
    @(posedge clk);
    erase_done <= 1'b0;
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // main sequence: rate change, frequency bounds, erase outcomes, busy refusal
  initial
  begin
    void'($urandom(32'h6b08d024));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    code = 8'h0A + 8'($urandom_range(1));
    run_cmd(FPSC_BAUD, {24'h0, code});
    check(result, ST_ACK);
    check(dev_baud_code, code);
    check(baud_code, code);
    fv = '{32'($urandom_range(FMAX, 1)), 32'h0, FMAX + 32'h1, FMAX};
    foreach (fv[i])
    begin
      run_cmd(FPSC_FREQ, fv[i]);
      check(result, freq_code(fv[i]));
      if (freq_code(fv[i]) == ST_ACK)
        check(osc_freq, fv[i]);
    end
    @(posedge clk);
    prohibit <= 1'b1;
    run_cmd(FPSC_ERASE, 32'h0);
    check(result, ST_PROTECT);
    prohibit <= 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      fork
        run_cmd(FPSC_ERASE, 32'h0);
        begin
          while (erase_req !== 1'b1) @(negedge clk);
          pulse_done(2'(r));
        end
      join
      check(result, erase_code(2'(r)));
      check(ok, r == 0);
    end
    run_cmd(FPSC_ERASE, 32'h0);
    check(timed_out, 1'b1);
    run_cmd(FPSC_FREQ, fv[0]);
    check(result, ST_NACK);
    pulse_done(2'h0);
    repeat (30000) @(posedge clk);
    check(dev_busy, 1'b0);
    run_cmd(FPSC_FREQ, fv[3]);
    check(result, ST_ACK);
    complete_run();
  end
endmodule

// ---- fpsc_dev.sv ----
// device end: command frame decoding and status replies
module fpsc_dev
  import fpsc_pkg::*;
#(
  parameter logic [31:0] FREQ_MIN = 32'h0000_0001,
  parameter logic [31:0] FREQ_MAX = 32'h00FF_FFFF
)(
  input  wire logic        clk,
  input  wire logic        rst,
  fpsc_link_if.dev         link,
  input  wire logic        erase_prohibit,
  input  wire logic        erase_done,
  input  wire logic [1:0]  erase_result,
  output logic             erase_req,
  output logic             busy,
  output logic [31:0]      osc_freq,
  output logic [7:0]       baud_code
);
  typedef enum {PS_SOH, PS_LEN, PS_COM, PS_DATA, PS_SUM, PS_ETX} fpsc_dev_ps_type;

  fpsc_dev_ps_type ps_r;
  logic [2:0]  sync_r;
  logic        lvl_r, rx_busy_r, rx_stb_r, txd_r;
  logic [15:0] rx_cnt_r, tx_cnt_r, div;
  logic [3:0]  rx_idx_r, tx_left_r;
  logic [7:0]  rx_sh_r, len_r, left_r, sum_r, com_r, baud_r, pend_code_r, cur_code_r;
  logic [9:0]  tx_sh_r;
  logic [31:0] dat_r, freq_r;
  logic        fr_stb_r, fr_bad_r, busy_r, req_r, resync_r, done_pend_r;
  logic        pend_r, act_r;
  logic [2:0]  idx_r;
  logic [4:0]  frames_r;
  logic [7:0]  erase_code_r, tx_byte, code;
  logic        want, tx_go, csum_ok, fr_good, freq_in, baud_ok;

  assign div     = baud_div(baud_r);
  assign csum_ok = (sum_r == 8'h00);
  assign fr_good = !fr_bad_r && csum_ok;
  assign freq_in = (dat_r >= FREQ_MIN) && (dat_r <= FREQ_MAX);
  assign baud_ok = fr_good && (dat_r[7:0] >= BAUD_MIN) && (dat_r[7:0] <= BAUD_MAX);
  assign tx_go   = act_r && (tx_left_r == 4'h0) && (tx_cnt_r == 16'h0000);
  assign link.d2p_txd = txd_r;
  assign erase_req = req_r;
  assign busy      = busy_r;
  assign osc_freq  = freq_r;
  assign baud_code = baud_r;

  // status frame byte for the current position
  always_comb
  begin
    case (idx_r)
      3'h0:    tx_byte = STX_B;
      3'h1:    tx_byte = STATUS_LEN;
      3'h2:    tx_byte = cur_code_r;
      3'h3:    tx_byte = 8'h00 - STATUS_LEN - cur_code_r;
      default: tx_byte = ETX_B;
    endcase
  end

  // reply decision for a finished frame or a finished erase
  always_comb
  begin
    want = 1'b0;
    code = ST_ACK;
    if (fr_stb_r && busy_r)
    begin
      want = (com_r != COM_STATUS);
      code = ST_NACK;
    end
    else if (fr_stb_r && resync_r)
      want = fr_good && (com_r == COM_RESET);
    else if (fr_stb_r && com_r != COM_BAUD) // baud command silent unless the device is busy
    begin
      want = 1'b1;
      if (fr_bad_r)
        code = ST_NACK;
      else if (!csum_ok)
        code = ST_CSUM;
      else if (com_r == COM_FREQ && !freq_in)
        code = ST_PARAM;
      else if (com_r == COM_ERASE)
      begin
        want = erase_prohibit;
        code = ST_PROTECT;
      end
    end
    else if (!fr_stb_r && done_pend_r)
    begin
      want = 1'b1;
      code = erase_code_r;
    end
  end

  // pin synchroniser, a change counts once the last two stages agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_r <= 3'h7;
      lvl_r  <= 1'b1;
    end
    else
    begin
      sync_r <= {sync_r[1:0], link.p2d_txd};
      if (sync_r[1] == sync_r[2])
        lvl_r <= sync_r[2];
    end
  end

  // receiver, samples each bit in its middle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_busy_r <= 1'b0;
      rx_stb_r  <= 1'b0;
      rx_cnt_r  <= 16'h0000;
      rx_idx_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
    end
    else
    begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r)
      begin
        rx_busy_r <= !lvl_r;
        rx_cnt_r  <= {1'b0, div[15:1]};
        rx_idx_r  <= 4'h0;
      end
      else if (rx_cnt_r != 16'h0000)
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      else
      begin
        rx_cnt_r <= div - 16'h0001;
        rx_idx_r <= rx_idx_r + 4'h1;
        if ((rx_idx_r == 4'h0 && lvl_r) || rx_idx_r == BIT_STOP)
          rx_busy_r <= 1'b0;
        if (rx_idx_r == BIT_STOP)
          rx_stb_r <= lvl_r;
        else if (rx_idx_r != 4'h0)
          rx_sh_r <= {lvl_r, rx_sh_r[7:1]};
      end
    end
  end

  // command frame parser, checksum runs over length through sum byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ps_r     <= PS_SOH;
      len_r    <= 8'h00;
      left_r   <= 8'h00;
      sum_r    <= 8'h00;
      com_r    <= 8'h00;
      dat_r    <= 32'h0000_0000;
      fr_stb_r <= 1'b0;
      fr_bad_r <= 1'b0;
    end
    else
    begin
      fr_stb_r <= 1'b0;
      if (rx_stb_r)
      begin
        case (ps_r)
          PS_SOH:
            if (rx_sh_r == SOH_B)
              ps_r <= PS_LEN;
          PS_LEN:
          begin
            len_r  <= rx_sh_r;
            sum_r  <= rx_sh_r;
            left_r <= rx_sh_r - 8'h01;
            ps_r   <= PS_COM;
          end
          PS_COM:
          begin
            com_r <= rx_sh_r;
            sum_r <= sum_r + rx_sh_r;
            ps_r  <= (left_r == 8'h00) ? PS_SUM : PS_DATA;
          end
          PS_DATA:
          begin
            dat_r  <= {dat_r[23:0], rx_sh_r};
            sum_r  <= sum_r + rx_sh_r;
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01)
              ps_r <= PS_SUM;
          end
          PS_SUM:
          begin
            sum_r <= sum_r + rx_sh_r;
            ps_r  <= PS_ETX;
          end
          default:
          begin
            fr_stb_r <= 1'b1;
            fr_bad_r <= (rx_sh_r != ETX_B) || (len_r != cmd_len(com_r));
            ps_r     <= PS_SOH;
          end
        endcase
      end
    end
  end

  // command effects: rate change, resync window, frequency, erase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      baud_r       <= BAUD_DEFAULT;
      resync_r     <= 1'b0;
      frames_r     <= 5'h00;
      freq_r       <= 32'h0000_0000;
      busy_r       <= 1'b0;
      req_r        <= 1'b0;
      done_pend_r  <= 1'b0;
      erase_code_r <= ST_ACK;
    end
    else
    begin
      req_r <= 1'b0;
      if (fr_stb_r && resync_r)
      begin
        frames_r <= frames_r + 5'h01;
        if (fr_good && com_r == COM_RESET)
          resync_r <= 1'b0;
        else if (frames_r == RESYNC_LIMIT - 5'h01)
        begin
          resync_r <= 1'b0; // give up silently at the base rate
          baud_r   <= BAUD_DEFAULT;
        end
      end
      else if (fr_stb_r && !busy_r && com_r == COM_BAUD && baud_ok)
      begin
        baud_r   <= dat_r[7:0];
        resync_r <= 1'b1;
        frames_r <= 5'h00;
      end
      else if (fr_stb_r && !busy_r && fr_good && com_r == COM_FREQ && freq_in)
        freq_r <= dat_r;
      else if (fr_stb_r && !busy_r && fr_good && com_r == COM_ERASE && !erase_prohibit)
      begin
        req_r  <= 1'b1;
        busy_r <= 1'b1;
      end
      // erase outcome, fault codes ordered write, erase margin, verify margin
      if (erase_done && busy_r)
      begin
        busy_r <= 1'b0;
        case (erase_result)
          2'h1:    erase_code_r <= ST_WRITE;
          2'h2:    erase_code_r <= ST_ERASE_MRG;
          2'h3:    erase_code_r <= ST_VERIFY_MRG;
          default: erase_code_r <= ST_ACK;
        endcase
      end
      if (erase_done && busy_r)
        done_pend_r <= 1'b1;
      else if (!fr_stb_r)
        done_pend_r <= 1'b0;
    end
  end

  // reply queue and status frame sender
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_r      <= 1'b0;
      pend_code_r <= ST_ACK;
      cur_code_r  <= ST_ACK;
      act_r       <= 1'b0;
      idx_r       <= 3'h0;
    end
    else
    begin
      if (want)
      begin
        pend_r      <= 1'b1;
        pend_code_r <= code;
      end
      else if (!act_r && pend_r)
        pend_r <= 1'b0;
      if (!act_r && pend_r)
      begin
        act_r      <= 1'b1;
        cur_code_r <= pend_code_r;
        idx_r      <= 3'h0;
      end
      else if (tx_go)
      begin
        idx_r <= idx_r + 3'h1;
        if (idx_r == 3'h4)
          act_r <= 1'b0;
      end
    end
  end

  // transmitter, start bit then eight data bits then stop bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_sh_r   <= 10'h3FF;
      tx_left_r <= 4'h0;
      tx_cnt_r  <= 16'h0000;
      txd_r     <= 1'b1;
    end
    else if (tx_go)
    begin
      tx_sh_r   <= {1'b1, tx_byte, 1'b0};
      tx_left_r <= FRAME_BITS;
      tx_cnt_r  <= 16'h0000;
    end
    else if (tx_cnt_r != 16'h0000)
      tx_cnt_r <= tx_cnt_r - 16'h0001; // stop bit runs its full length too
    else if (tx_left_r != 4'h0)
    begin
      txd_r     <= tx_sh_r[0];
      tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
      tx_left_r <= tx_left_r - 4'h1;
      tx_cnt_r  <= div - 16'h0001;
    end
  end
endmodule

// ---- fpsc_link_if.sv ----
// serial link wires between the programmer end and the device end
interface fpsc_link_if;
  logic p2d_txd; // programmer to device line, idle high
  logic d2p_txd; // device to programmer line, idle high
  modport prog (output p2d_txd, input d2p_txd);
  modport dev  (input p2d_txd, output d2p_txd);
endinterface

// ---- fpsc_pkg.sv ----
// shared constants, types and helpers for the flash programming command link
package fpsc_pkg;
  localparam int CLK_HZ  = 40_000_000;
  localparam int CLK_MHZ = 40;
  localparam int CLK_KHZ = 40_000;

  // frame delimiters and status frame length
  localparam logic [7:0] SOH_B = 8'h01;
  localparam logic [7:0] STX_B = 8'h02;
  localparam logic [7:0] ETX_B = 8'h03;
  localparam logic [7:0] STATUS_LEN = 8'h01;

  // status codes carried in first_status_byte
  localparam logic [7:0] ST_ACK        = 8'h06;
  localparam logic [7:0] ST_PARAM      = 8'h05;
  localparam logic [7:0] ST_CSUM       = 8'h07;
  localparam logic [7:0] ST_PROTECT    = 8'h10;
  localparam logic [7:0] ST_NACK       = 8'h15;
  localparam logic [7:0] ST_WRITE      = 8'h1C;
  localparam logic [7:0] ST_ERASE_MRG  = 8'h1A;
  localparam logic [7:0] ST_VERIFY_MRG = 8'h1B;

  // command codes
  localparam logic [7:0] COM_RESET  = 8'h00;
  localparam logic [7:0] COM_BAUD   = 8'h9A;
  localparam logic [7:0] COM_FREQ   = 8'h90;
  localparam logic [7:0] COM_ERASE  = 8'h20;
  localparam logic [7:0] COM_STATUS = 8'h70;

  // frame_length_field values per command
  localparam logic [7:0] LEN_PLAIN = 8'h01;
  localparam logic [7:0] LEN_BAUD  = 8'h02;
  localparam logic [7:0] LEN_FREQ  = 8'h05;

  // bit rate codes
  localparam logic [7:0] BAUD_MIN     = 8'h03;
  localparam logic [7:0] BAUD_MAX     = 8'h0B;
  localparam logic [7:0] BAUD_DEFAULT = 8'h03;

  localparam logic [4:0] RESYNC_LIMIT = 5'h10;
  localparam logic [3:0] BIT_STOP     = 4'h9;
  localparam logic [3:0] FRAME_BITS   = 4'hA;

  typedef enum logic [1:0] {FPSC_BAUD, FPSC_FREQ, FPSC_ERASE} fpsc_kind_type;

  // clock cycles per bit for a rate code
  function automatic logic [15:0] baud_div(input logic [7:0] code);
    case (code)
      8'h04:   baud_div = 16'(CLK_HZ / 19200);
      8'h05:   baud_div = 16'(CLK_HZ / 31250);
      8'h06:   baud_div = 16'(CLK_HZ / 38400);
      8'h07:   baud_div = 16'(CLK_HZ / 76800);
      8'h08:   baud_div = 16'(CLK_HZ / 153600);
      8'h09:   baud_div = 16'(CLK_HZ / 57600);
      8'h0A:   baud_div = 16'(CLK_HZ / 115200);
      8'h0B:   baud_div = 16'(CLK_HZ / 128000);
      default: baud_div = 16'(CLK_HZ / 9600);
    endcase
  endfunction

  // expected frame_length_field of a command, zero when unknown
  function automatic logic [7:0] cmd_len(input logic [7:0] com);
    case (com)
      COM_RESET, COM_ERASE, COM_STATUS: cmd_len = LEN_PLAIN;
      COM_BAUD: cmd_len = LEN_BAUD;
      COM_FREQ: cmd_len = LEN_FREQ;
      default:  cmd_len = 8'h00;
    endcase
  endfunction
endpackage

// ---- fpsc_prog.sv ----
// programmer end: sends rate, frequency and erase commands, collects status
// Summary of operation
// - wait inter_command_gap after last received frame
// - after rate command, wait then send reset
// - reset reply timeout gives a time-out error
// - at most sixteen resync reset transmissions
// - acknowledge ends the rate change normally
// - device acknowledges once new speed is synchronised
// - device reports bad checksum with 07H
// - device reports malformed frame with 15H
// - device stays silent on rate command faults
// - frequency reply timeout gives a time-out error
// - device answers 05H for bad frequency
// - device refuses non-status commands while busy
// - erase reply timeout gives a time-out error
// - device answers 10H when erase is prohibited
// - device reports erase failure as 1CH/1AH/1BH
// - acknowledge is success, other codes are failure
module fpsc_prog
  import fpsc_pkg::*;
#(
  parameter int GAP_US       = 1000,
  parameter int SWITCH_US    = 1000,
  parameter int RESET_TMO_MS = 100,
  parameter int FREQ_TMO_MS  = 100,
  parameter int ERASE_TMO_MS = 20000
)(
  input  wire logic          clk,
  input  wire logic          rst,
  fpsc_link_if.prog          link,
  input  wire logic          cmd_start,
  input  wire fpsc_kind_type cmd_kind,
  input  wire logic [31:0]   cmd_arg,
  output logic               busy,
  output logic               done,
  output logic               ok,
  output logic               timed_out,
  output logic [7:0]         result,
  output logic [7:0]         baud_code
);
  // least waits in cycles, longest waits in cycles
  localparam logic [31:0] GAP_CYC       = 32'(GAP_US * CLK_MHZ);
  localparam logic [31:0] SWITCH_CYC    = 32'(SWITCH_US * CLK_MHZ);
  localparam logic [31:0] RESET_TMO_CYC = 32'(RESET_TMO_MS * CLK_KHZ);
  localparam logic [31:0] FREQ_TMO_CYC  = 32'(FREQ_TMO_MS * CLK_KHZ);
  localparam logic [31:0] ERASE_TMO_CYC = 32'(ERASE_TMO_MS * CLK_KHZ);

  typedef enum {PG_IDLE, PG_GAP, PG_SEND, PG_SWITCH, PG_WAIT} fpsc_pg_type;

  fpsc_pg_type   st_r;
  fpsc_kind_type kind_r;
  logic [31:0]   arg_r, tmr_r, gap_r, tmo_cyc;
  logic [2:0]    sync_r;
  logic          lvl_r, rx_busy_r, rx_stb_r, txd_r, resync_r;
  logic [15:0]   rx_cnt_r, tx_cnt_r, div;
  logic [3:0]    rx_idx_r, tx_left_r, idx_r, last_idx;
  logic [7:0]    rx_sh_r, baud_r, st1_r, result_r, tx_byte, com, len, dsum, data_b;
  logic [9:0]    tx_sh_r;
  logic [2:0]    pos_r;
  logic [4:0]    tries_r;
  logic          st_stb_r, busy_r, done_r, ok_r, tmo_r, tx_go, sent, retry_ok, tx_idle;

  assign div      = baud_div(baud_r);
  assign com      = resync_r ? COM_RESET :
                    (kind_r == FPSC_BAUD) ? COM_BAUD :
                    (kind_r == FPSC_FREQ) ? COM_FREQ : COM_ERASE;
  assign len      = resync_r ? LEN_PLAIN : cmd_len(com);
  assign last_idx = len[3:0] + 4'h3;
  assign dsum     = (len == LEN_FREQ) ? arg_r[31:24] + arg_r[23:16] + arg_r[15:8] + arg_r[7:0] :
                    (len == LEN_BAUD) ? arg_r[7:0] : 8'h00;
  assign tx_idle  = (tx_left_r == 4'h0) && (tx_cnt_r == 16'h0000); // stop bit fully out
  assign tx_go    = (st_r == PG_SEND) && tx_idle && (idx_r <= last_idx);
  assign sent     = (st_r == PG_SEND) && tx_idle && (idx_r > last_idx);
  assign retry_ok = resync_r && (tries_r < RESYNC_LIMIT);
  assign tmo_cyc  = resync_r ? RESET_TMO_CYC :
                    (kind_r == FPSC_FREQ) ? FREQ_TMO_CYC : ERASE_TMO_CYC;
  assign link.p2d_txd = txd_r;
  assign busy      = busy_r;
  assign done      = done_r;
  assign ok        = ok_r;
  assign timed_out = tmo_r;
  assign result    = result_r;
  assign baud_code = baud_r;

  // command frame byte for the current position
  always_comb
  begin
    case (idx_r)
      4'h3:    data_b = (len == LEN_FREQ) ? arg_r[31:24] : arg_r[7:0];
      4'h4:    data_b = arg_r[23:16];
      4'h5:    data_b = arg_r[15:8];
      default: data_b = arg_r[7:0];
    endcase
    if (idx_r == 4'h0)
      tx_byte = SOH_B;
    else if (idx_r == 4'h1)
      tx_byte = len;
    else if (idx_r == 4'h2)
      tx_byte = com;
    else if (idx_r == last_idx - 4'h1)
      tx_byte = 8'h00 - len - com - dsum;
    else if (idx_r == last_idx)
      tx_byte = ETX_B;
    else
      tx_byte = data_b;
  end

  // pin synchroniser, a change counts once the last two stages agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_r <= 3'h7;
      lvl_r  <= 1'b1;
    end
    else
    begin
      sync_r <= {sync_r[1:0], link.d2p_txd};
      if (sync_r[1] == sync_r[2])
        lvl_r <= sync_r[2];
    end
  end

  // receiver, samples each bit in its middle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_busy_r <= 1'b0;
      rx_stb_r  <= 1'b0;
      rx_cnt_r  <= 16'h0000;
      rx_idx_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
    end
    else
    begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r)
      begin
        rx_busy_r <= !lvl_r;
        rx_cnt_r  <= {1'b0, div[15:1]};
        rx_idx_r  <= 4'h0;
      end
      else if (rx_cnt_r != 16'h0000)
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      else
      begin
        rx_cnt_r <= div - 16'h0001;
        rx_idx_r <= rx_idx_r + 4'h1;
        if ((rx_idx_r == 4'h0 && lvl_r) || rx_idx_r == BIT_STOP)
          rx_busy_r <= 1'b0;
        if (rx_idx_r == BIT_STOP)
          rx_stb_r <= lvl_r;
        else if (rx_idx_r != 4'h0)
          rx_sh_r <= {lvl_r, rx_sh_r[7:1]};
      end
    end
  end

  // status frame collector and gap timer since last received frame
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_r    <= 3'h0;
      st1_r    <= 8'h00;
      st_stb_r <= 1'b0;
      gap_r    <= 32'h0000_0000;
    end
    else
    begin
      st_stb_r <= 1'b0;
      if (gap_r < GAP_CYC)
        gap_r <= gap_r + 32'h0000_0001;
      if (rx_stb_r)
      begin
        pos_r <= (pos_r == 3'h4 || (pos_r == 3'h0 && rx_sh_r != STX_B)) ? 3'h0 : pos_r + 3'h1;
        if (pos_r == 3'h2)
          st1_r <= rx_sh_r;
        if (pos_r == 3'h4 && rx_sh_r == ETX_B)
        begin
          st_stb_r <= 1'b1;
          gap_r    <= 32'h0000_0000;
        end
      end
    end
  end

  // command sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r     <= PG_IDLE;
      kind_r   <= FPSC_BAUD;
      arg_r    <= 32'h0000_0000;
      tmr_r    <= 32'h0000_0000;
      idx_r    <= 4'h0;
      tries_r  <= 5'h00;
      resync_r <= 1'b0;
      baud_r   <= BAUD_DEFAULT;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      ok_r     <= 1'b0;
      tmo_r    <= 1'b0;
      result_r <= 8'h00;
    end
    else
    begin
      done_r <= 1'b0;
      if (tx_go)
        idx_r <= idx_r + 4'h1;
      if (tmr_r != 32'h0000_0000)
        tmr_r <= tmr_r - 32'h0000_0001;
      case (st_r)
        PG_IDLE:
          if (cmd_start)
          begin
            kind_r   <= cmd_kind;
            arg_r    <= cmd_arg;
            resync_r <= 1'b0;
            tries_r  <= 5'h00;
            busy_r   <= 1'b1;
            st_r     <= PG_GAP;
          end
        PG_GAP:
          if (gap_r >= GAP_CYC)
          begin
            idx_r <= 4'h0;
            st_r  <= PG_SEND;
          end
        PG_SEND:
          if (sent && kind_r == FPSC_BAUD && !resync_r)
          begin
            baud_r <= arg_r[7:0];
            tmr_r  <= SWITCH_CYC;
            st_r   <= PG_SWITCH;
          end
          else if (sent)
          begin
            tmr_r <= tmo_cyc;
            st_r  <= PG_WAIT;
          end
        PG_SWITCH:
          if (tmr_r == 32'h0000_0000)
          begin
            resync_r <= 1'b1;
            tries_r  <= tries_r + 5'h01;
            idx_r    <= 4'h0;
            st_r     <= PG_SEND;
          end
        PG_WAIT:
          if ((st_stb_r && st1_r != ST_ACK && retry_ok) ||
              (!st_stb_r && tmr_r == 32'h0000_0000 && retry_ok))
          begin
            tmr_r <= SWITCH_CYC;
            st_r  <= PG_SWITCH;
          end
          else if (st_stb_r || tmr_r == 32'h0000_0000)
          begin
            tmo_r    <= !st_stb_r;
            ok_r     <= st_stb_r && (st1_r == ST_ACK);
            result_r <= st_stb_r ? st1_r : 8'h00;
            done_r   <= 1'b1;
            busy_r   <= 1'b0;
            st_r     <= PG_IDLE;
          end
        default:
          st_r <= PG_IDLE;
      endcase
    end
  end

  // transmitter, start bit then eight data bits then stop bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_sh_r   <= 10'h3FF;
      tx_left_r <= 4'h0;
      tx_cnt_r  <= 16'h0000;
      txd_r     <= 1'b1;
    end
    else if (tx_go)
    begin
      tx_sh_r   <= {1'b1, tx_byte, 1'b0};
      tx_left_r <= FRAME_BITS;
      tx_cnt_r  <= 16'h0000;
    end
    else if (tx_cnt_r != 16'h0000)
      tx_cnt_r <= tx_cnt_r - 16'h0001; // stop bit runs its full length too
    else if (tx_left_r != 4'h0)
    begin
      txd_r     <= tx_sh_r[0];
      tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
      tx_left_r <= tx_left_r - 4'h1;
      tx_cnt_r  <= div - 16'h0001;
    end
  end
endmodule

// ---- fpsc_properties.sv ----
// concurrent checks on the link and user ports of both ends
module fpsc_properties
  import fpsc_pkg::*;
#(
  parameter int GAP_CYC = 40
)(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       p2d_txd,
  input wire logic       d2p_txd,
  input wire logic       cmd_start,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       ok,
  input wire logic       timed_out,
  input wire logic [7:0] result,
  input wire logic [7:0] baud_code,
  input wire logic [7:0] dev_baud_code,
  input wire logic       erase_req,
  input wire logic       dev_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since the device line was last low, saturating
  logic [15:0] quiet_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      quiet_r <= '0;
    else if (!d2p_txd)
      quiet_r <= '0;
    else if (quiet_r != 16'hFFFF)
      quiet_r <= quiet_r + 16'h0001;

  // a command accepted by an idle programmer, and a completion pulse
  sequence s_start;
    !busy && cmd_start;
  endsequence
  sequence s_done_end;
    ##1 (!done && !busy);
  endsequence

  a_gap_kept: assert property ($fell(p2d_txd) |-> quiet_r >= GAP_CYC)
    else $error("programmer started a frame inside the command gap");
  a_half_duplex: assert property (!d2p_txd |-> p2d_txd)
    else $error("programmer sent while the device was answering");
  a_start_holds: assert property (s_start |=> busy [*8])
    else $error("busy did not follow an accepted command");
  a_done_ends: assert property (done |-> s_done_end)
    else $error("done pulse did not end the command");
  a_ok_is_ack: assert property (done |-> ok == (result == ST_ACK))
    else $error("ok disagrees with the status code");
  a_timeout_code: assert property (done && timed_out |-> !ok && result == 8'h00)
    else $error("time-out reported with a status code");
  a_rate_agree: assert property (done && ok |-> baud_code == dev_baud_code)
    else $error("ends disagree on bit rate after success");
  a_erase_busy: assert property (erase_req |-> ##[0:1] dev_busy)
    else $error("device not busy after accepting erase");
endmodule
